// [inc/servo_if_map.vh]
// register offsets, field positions and timing counts of the servo driver interface
`ifndef SERVO_IF_MAP_VH
`define SERVO_IF_MAP_VH
`define ADDR_OPERATION_MODE    4'h0
`define ADDR_ENV_SETTING_1     4'h1
`define ADDR_EXT_STATUS        4'h2
`define ADDR_SUB_STATUS        4'h3
`define ADDR_ERR_STOP_CAUSE    4'h4
`define ADDR_COMMAND           4'h5
`define ADDR_AXIS_EVENT        4'h6
`define ADDR_AXIS_STATUS       4'h7
`define BIT_WAIT_INPOS         9
`define BIT_ALM_STOP_METHOD    8
`define BIT_ALM_POLARITY       9
`define BIT_CLR_ON_HARD_STOP   10
`define BIT_CLR_ON_HOME_DONE   11
`define LSB_CLR_WIDTH          12
`define BIT_CLR_POLARITY       15
`define LSB_CLR_OFF_TIMER      16
`define BIT_INPOS_POLARITY     22
`define BIT_FILTER_EN          26
`define BIT_STS_CLR_STATE      9
`define BIT_STS_INPOS          16
`define BIT_SUB_ALARM          11
`define BIT_EST_ALARM          7
`define CMD_EMERGENCY_STOP     8'h05
`define CMD_CLEAR_ON           8'h24
`define CMD_CLEAR_OFF          8'h25
`define CLK_MHZ                125
`define FILTER_CYCLES          7'h50
`define NOFILTER_CYCLES        7'h02
`define CNT_W                  24
`define COND_IDLE              4'h0
`define COND_RUN               4'h1
`define COND_WAIT_INPOS        4'h3
`define EV_START_LS            0
`define EV_START_HS            1
`define EV_PULSE_DONE          2
`define EV_HOME_DONE           3
`define EV_LIMIT_STOP          4
`define EV_EMG_STOP            5
`define EV_DECEL_DONE          6
`endif

// [rtl/servo_driver_interface.v]
// servo driver interface: in-position completion, deviation clear and alarm handling
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "servo_if_map.vh"
module servo_driver_interface
(
  input  wire        mclk_i,
  input  wire        srst_i,
  input  wire [3:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  input  wire        in_position_input_i,
  input  wire        alarm_input_i,
  output reg         deviation_clear_output_o,
  output reg         busy_output_o,
  output reg         pulse_enable_o,
  output reg         decel_request_o,
  output reg         immediate_stop_o
);
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_RUN   = 2'h1;
  localparam [1:0] ST_DECEL = 2'h2;
  localparam [1:0] ST_INPOS = 2'h3;
  localparam [31:0] T12US_CYC  = 32'd12 * `CLK_MHZ;
  localparam [31:0] T102US_CYC = 32'd102 * `CLK_MHZ;
  localparam [31:0] T408US_CYC = 32'd408 * `CLK_MHZ;
  localparam [31:0] T1P6MS_CYC = 32'd1600 * `CLK_MHZ;
  localparam [31:0] T13MS_CYC  = 32'd13000 * `CLK_MHZ;
  localparam [31:0] T52MS_CYC  = 32'd52000 * `CLK_MHZ;
  localparam [31:0] T104MS_CYC = 32'd104000 * `CLK_MHZ;

  reg [31:0] operation_mode_ff;
  reg [31:0] environment_setting_1_ff;
  reg [31:0] error_stop_cause_ff;
  reg [6:0]  event_ff;
  reg [1:0]  state_ff;
  reg        high_speed_ff;
  reg        home_run_ff;
  reg        clr_on_ff;
  reg        clr_level_ff;
  reg [`CNT_W-1:0] clr_cnt_ff;
  reg [`CNT_W-1:0] off_cnt_ff;
  reg [3:0]  cond_ff;
  reg [5:0]  stop_bits_ff;
  reg [1:0]  nxt_state;
  reg [`CNT_W-1:0] width_cyc;
  reg [`CNT_W-1:0] off_cyc;
  wire       inpos_on;
  wire       alarm_on;
  wire       cmd_wr;
  wire       ev_wr;
  wire       hard_stop;
  wire       clr_start;
  wire       clr_stop;
  wire       done_now;
  wire [1:0] pin_vec;
  wire [1:0] pol_vec;
  wire [1:0] on_vec;
  genvar     gi;

  // entry 0 in-position, entry 1 alarm
  assign pin_vec  = {alarm_input_i, in_position_input_i};
  assign pol_vec  = {environment_setting_1_ff[`BIT_ALM_POLARITY],
                     environment_setting_1_ff[`BIT_INPOS_POLARITY]};
  assign inpos_on = on_vec[0];
  assign alarm_on = on_vec[1];

  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_servo_in
      servo_in_filter u_filter
      (
        .mclk_i        (mclk_i),
        .srst_i        (srst_i),
        .pin_i         (pin_vec[gi]),
        .active_high_i (pol_vec[gi]),
        .filter_en_i   (environment_setting_1_ff[`BIT_FILTER_EN]),
        .on_o          (on_vec[gi])
      );
    end
  endgenerate

  assign cmd_wr = wr_i && addr_i == `ADDR_COMMAND;
  assign ev_wr  = wr_i && addr_i == `ADDR_AXIS_EVENT;

  // stop events from the pulse generator arrive as one-cycle writes of axis events
  assign done_now = (state_ff == ST_RUN && ev_wr && wdata_i[`EV_PULSE_DONE])
                 || (state_ff == ST_DECEL && ev_wr && wdata_i[`EV_DECEL_DONE]);

  assign hard_stop = (state_ff != ST_IDLE)
                  && ((alarm_on && (!environment_setting_1_ff[`BIT_ALM_STOP_METHOD]
                                    || !high_speed_ff))
                      || (ev_wr && (wdata_i[`EV_LIMIT_STOP] || wdata_i[`EV_EMG_STOP]))
                      || (cmd_wr && wdata_i[7:0] == `CMD_EMERGENCY_STOP));

  assign clr_start = (cmd_wr && wdata_i[7:0] == `CMD_CLEAR_ON)
                  || (hard_stop && environment_setting_1_ff[`BIT_CLR_ON_HARD_STOP])
                  || (done_now && home_run_ff
                      && environment_setting_1_ff[`BIT_CLR_ON_HOME_DONE]);

  // an off command while already off leaves the off timer alone
  assign clr_stop = clr_on_ff
                 && ((cmd_wr && wdata_i[7:0] == `CMD_CLEAR_OFF)
                     || (!clr_level_ff && clr_cnt_ff == {`CNT_W{1'b0}}));

  always @*
  begin
    case (environment_setting_1_ff[`LSB_CLR_WIDTH+2:`LSB_CLR_WIDTH])
      3'h0:    width_cyc = T12US_CYC[`CNT_W-1:0];
      3'h1:    width_cyc = T102US_CYC[`CNT_W-1:0];
      3'h2:    width_cyc = T408US_CYC[`CNT_W-1:0];
      3'h3:    width_cyc = T1P6MS_CYC[`CNT_W-1:0];
      3'h4:    width_cyc = T13MS_CYC[`CNT_W-1:0];
      3'h5:    width_cyc = T52MS_CYC[`CNT_W-1:0];
      3'h6:    width_cyc = T104MS_CYC[`CNT_W-1:0];
      default: width_cyc = {`CNT_W{1'b0}};
    endcase
    case (environment_setting_1_ff[`LSB_CLR_OFF_TIMER+1:`LSB_CLR_OFF_TIMER])
      2'h1:    off_cyc = T12US_CYC[`CNT_W-1:0];
      2'h2:    off_cyc = T1P6MS_CYC[`CNT_W-1:0];
      2'h3:    off_cyc = T104MS_CYC[`CNT_W-1:0];
      default: off_cyc = {`CNT_W{1'b0}};
    endcase
  end

  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (ev_wr && (wdata_i[`EV_START_LS] || wdata_i[`EV_START_HS])
            && !alarm_on && off_cnt_ff == {`CNT_W{1'b0}})
          nxt_state = ST_RUN;
      ST_RUN:
        if (hard_stop)
          nxt_state = ST_IDLE;
        else if (alarm_on)
          nxt_state = ST_DECEL;
        else if (done_now)
          nxt_state = operation_mode_ff[`BIT_WAIT_INPOS] ? ST_INPOS : ST_IDLE;
      ST_DECEL:
        if (hard_stop || done_now)
          nxt_state = operation_mode_ff[`BIT_WAIT_INPOS] && !hard_stop ? ST_INPOS : ST_IDLE;
      ST_INPOS:
        if (hard_stop || inpos_on)
          nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      operation_mode_ff        <= 32'h00000000;
      environment_setting_1_ff <= 32'h00000000;
      error_stop_cause_ff      <= 32'h00000000;
      event_ff                 <= 7'h00;
      state_ff                 <= ST_IDLE;
      high_speed_ff            <= 1'b0;
      home_run_ff              <= 1'b0;
      clr_on_ff                <= 1'b0;
      clr_level_ff             <= 1'b0;
      clr_cnt_ff               <= {`CNT_W{1'b0}};
      off_cnt_ff               <= {`CNT_W{1'b0}};
      cond_ff                  <= `COND_IDLE;
      stop_bits_ff             <= 6'h00;
      rdata_o                  <= 32'h00000000;
      // idle level of the active-low reset polarity: no clear during reset
      deviation_clear_output_o <= 1'b1;
      busy_output_o            <= 1'b0;
      pulse_enable_o           <= 1'b0;
      decel_request_o          <= 1'b0;
      immediate_stop_o         <= 1'b0;
    end
    else
    begin
      if (wr_i && addr_i == `ADDR_OPERATION_MODE)
        operation_mode_ff <= wdata_i;
      if (wr_i && addr_i == `ADDR_ENV_SETTING_1)
        environment_setting_1_ff <= wdata_i;
      state_ff <= nxt_state;
      if (ev_wr)
        event_ff <= wdata_i[6:0];
      if (state_ff == ST_IDLE && nxt_state == ST_RUN)
      begin
        high_speed_ff       <= wdata_i[`EV_START_HS];
        home_run_ff         <= wdata_i[`EV_HOME_DONE];
        error_stop_cause_ff <= 32'h00000000;
      end
      // cause set by the stop holds until the clear at the next start
      if (state_ff != ST_IDLE && alarm_on)
        error_stop_cause_ff[`BIT_EST_ALARM] <= 1'b1;
      // completion status moves together with busy
      if (nxt_state == ST_IDLE && state_ff != ST_IDLE)
      begin
        cond_ff      <= `COND_IDLE;
        stop_bits_ff <= {hard_stop, alarm_on, 1'b0, done_now, 1'b1, 1'b1};
      end
      else if (nxt_state == ST_RUN || nxt_state == ST_DECEL)
      begin
        cond_ff      <= `COND_RUN;
        stop_bits_ff <= 6'h00;
      end
      else if (nxt_state == ST_INPOS)
        cond_ff <= `COND_WAIT_INPOS;
      busy_output_o    <= nxt_state != ST_IDLE;
      pulse_enable_o   <= nxt_state == ST_RUN || nxt_state == ST_DECEL;
      decel_request_o  <= nxt_state == ST_DECEL;
      immediate_stop_o <= hard_stop;
      if (clr_start)
      begin
        clr_on_ff    <= 1'b1;
        clr_level_ff <= width_cyc == {`CNT_W{1'b0}};
        clr_cnt_ff   <= width_cyc - {{(`CNT_W-1){1'b0}}, 1'b1};
      end
      else if (clr_stop)
      begin
        clr_on_ff  <= 1'b0;
        off_cnt_ff <= off_cyc;
      end
      else
      begin
        if (clr_on_ff && clr_cnt_ff != {`CNT_W{1'b0}})
          clr_cnt_ff <= clr_cnt_ff - {{(`CNT_W-1){1'b0}}, 1'b1};
        if (off_cnt_ff != {`CNT_W{1'b0}})
          off_cnt_ff <= off_cnt_ff - {{(`CNT_W-1){1'b0}}, 1'b1};
      end
      deviation_clear_output_o <= (clr_start || (clr_on_ff && !clr_stop))
                                  == environment_setting_1_ff[`BIT_CLR_POLARITY];
      rdata_o <= 32'h00000000;
      if (rd_i)
      begin
        case (addr_i)
          `ADDR_OPERATION_MODE: rdata_o <= operation_mode_ff;
          `ADDR_ENV_SETTING_1:  rdata_o <= environment_setting_1_ff;
          `ADDR_EXT_STATUS:
          begin
            rdata_o[3:0]                <= cond_ff;
            rdata_o[`BIT_STS_CLR_STATE] <= clr_on_ff;
            rdata_o[`BIT_STS_INPOS]     <= inpos_on;
          end
          `ADDR_SUB_STATUS:     rdata_o[`BIT_SUB_ALARM] <= alarm_on;
          `ADDR_ERR_STOP_CAUSE: rdata_o <= error_stop_cause_ff;
          `ADDR_AXIS_EVENT:     rdata_o[6:0] <= event_ff;
          `ADDR_AXIS_STATUS:
          begin
            rdata_o[5:0] <= stop_bits_ff;
            rdata_o[9:8] <= state_ff;
            rdata_o[16]  <= off_cnt_ff != {`CNT_W{1'b0}};
          end
          default:              rdata_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/servo_in_filter.v]
// one servo input: synchroniser, stable-width filter and polarity
`timescale 1ns/1ps
`default_nettype none
`include "servo_if_map.vh"
module servo_in_filter
(
  input  wire mclk_i,
  input  wire srst_i,
  input  wire pin_i,
  input  wire active_high_i,
  input  wire filter_en_i,
  output reg  on_o
);
  reg       meta_ff;
  reg       sync_ff;
  reg       last_ff;
  reg [6:0] stable_ff;
  wire [6:0] need;
  wire       lvl;
  assign need = filter_en_i ? `FILTER_CYCLES : `NOFILTER_CYCLES;
  assign lvl  = active_high_i ? sync_ff : ~sync_ff;
  // sampling chain runs through reset, so the first compare after it
  // sees the real pin level and no false edge
  always @(posedge mclk_i)
  begin
    meta_ff <= pin_i;
    sync_ff <= meta_ff;
    last_ff <= lvl;
  end
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      stable_ff <= 7'h00;
      on_o      <= 1'b0;
    end
    else
    begin
      if (lvl != last_ff)
        stable_ff <= 7'h01;
      else if (stable_ff < need)
        stable_ff <= stable_ff + 7'h01;
      if (lvl == last_ff && stable_ff + 7'h01 >= need)
        on_o <= lvl;
    end
  end
endmodule
`default_nettype wire

// [tb/servo_drv_model.sv]
// servo driver model: settling and fault pins with selectable levels
`timescale 1ns/1ps
`default_nettype none
`include "servo_if_map.vh"
module servo_drv_model
(
  input  wire logic        settled_i,
  input  wire logic        fault_i,
  input  wire logic        clr_i,
  input  wire logic [31:0] env_i,
  output logic             inp_pin_o,
  output logic             alm_pin_o
);
  logic clr_on;
  assign clr_on    = clr_i ~^ env_i[`BIT_CLR_POLARITY];
  // pins follow the commanded level for as long as it is held
  // a cleared deviation counter reads as settled
  assign inp_pin_o = (settled_i | clr_on) ~^ env_i[`BIT_INPOS_POLARITY];
  assign alm_pin_o = fault_i ~^ env_i[`BIT_ALM_POLARITY];
endmodule
`default_nettype wire

// [tb/servo_if_sva.sv]
// port assertions of the servo driver interface
`timescale 1ns/1ps
`default_nettype none
`include "servo_if_map.vh"
module servo_if_sva
(
  input wire logic        mclk_i,
  input wire logic        srst_i,
  input wire logic [3:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        in_position_input_i,
  input wire logic        alarm_input_i,
  input wire logic        deviation_clear_output_o,
  input wire logic        busy_output_o,
  input wire logic        pulse_enable_o,
  input wire logic        decel_request_o,
  input wire logic        immediate_stop_o
);
  reg pol_ff;
  reg wait_ff;
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      pol_ff  <= 1'b0;
      wait_ff <= 1'b0;
    end
    else if (wr_i && addr_i == `ADDR_ENV_SETTING_1)
      pol_ff  <= wdata_i[`BIT_CLR_POLARITY];
    else if (wr_i && addr_i == `ADDR_OPERATION_MODE)
      wait_ff <= wdata_i[`BIT_WAIT_INPOS];
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  sequence cmd_wr(logic [7:0] c);
    wr_i && addr_i == `ADDR_COMMAND && wdata_i[7:0] == c;
  endsequence
  sequence done_run;
    wr_i && addr_i == `ADDR_AXIS_EVENT && wdata_i[`EV_PULSE_DONE]
      && pulse_enable_o && !decel_request_o;
  endsequence
  a_rdata_idle_zero:
    assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not zero outside answer cycle");
  a_clear_cmd_on:
    assert property (cmd_wr(`CMD_CLEAR_ON) |=> deviation_clear_output_o == pol_ff)
    else $error("clear output not active after on command");
  a_clear_cmd_off:
    assert property (cmd_wr(`CMD_CLEAR_OFF) |=> deviation_clear_output_o != pol_ff)
    else $error("clear output still active after off command");
  a_stop_one_cycle:
    assert property (immediate_stop_o |=> !immediate_stop_o)
    else $error("stop pulse longer than one cycle");
  a_stop_ends_run:
    assert property (immediate_stop_o |-> ##[0:1] (!busy_output_o && !pulse_enable_o))
    else $error("axis still running after immediate stop");
  a_decel_in_run:
    assert property (decel_request_o |-> pulse_enable_o && busy_output_o)
    else $error("deceleration outside a running operation");
  a_done_no_wait:
    assert property (done_run ##0 !wait_ff |=> !busy_output_o)
    else $error("busy held after done without wait");
  a_pulse_needs_busy:
    assert property (pulse_enable_o |-> busy_output_o)
    else $error("pulses enabled while not busy");
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench of the servo driver interface
`timescale 1ns/1ps
`default_nettype none
`include "servo_if_map.vh"
module testbench;
  localparam logic [31:0] BASE = 32'h0040_8200;
  localparam logic [3:0]  EXT  = `ADDR_EXT_STATUS;
  logic        mclk_i  = 1'b0;
  logic        srst_i  = 1'b1;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  logic        settled = 1'b0;
  logic        fault   = 1'b0;
  logic [3:0]  addr_i  = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] env     = 32'h0;
  wire  [31:0] rdata_o;
  wire         inp, alarm_input, clr, busy, pen, dec, stp;
  int          n_stp = 0;
  int          stp_mark = 0;
  // index 0 clear, 1 idle, 2 pulses, 3 decel, 4 stop pulse seen since the mark
  wire  [4:0]  outs = {n_stp != stp_mark, dec, pen, !busy, clr};
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          n;
  servo_driver_interface i_dut
  (
    .mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .in_position_input_i(inp), .alarm_input_i(alarm_input),
    .deviation_clear_output_o(clr), .busy_output_o(busy), .pulse_enable_o(pen),
    .decel_request_o(dec), .immediate_stop_o(stp)
  );
  servo_drv_model i_drv
  (
    .settled_i(settled), .fault_i(fault), .clr_i(clr), .env_i(env),
    .inp_pin_o(inp), .alm_pin_o(alarm_input)
  );
  initial forever #4 mclk_i = ~mclk_i;
  // the one-cycle stop pulse is counted at the falling edge, where it has settled
  always @(negedge mclk_i)
    if (stp === 1'b1)
      n_stp++;
  task automatic tick(int k = 1);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    tick();
    wr_i    <= 1'b0;
    tick();
  endtask
  task automatic ev(int b);
    wr(`ADDR_AXIS_EVENT, 32'h1 << b);
  endtask
  task automatic setenv(logic [31:0] v);
    env = v;
    wr(`ADDR_ENV_SETTING_1, v);
  endtask
  task automatic rdc(string nm, logic [3:0] a, logic [31:0] m, logic [31:0] e);
    addr_i <= a;
    rd_i   <= 1'b1;
    tick();
    rd_i   <= 1'b0;
    chk(nm, rdata_o & m, e);
    tick();
  endtask
  task automatic await(string nm, int s, int lim);
    for (n = 0; n < lim && outs[s] !== 1'b1; n++)
      tick();
    chk(nm, outs[s], 1);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic t_done();
    int w;
    rdc("unmapped", 4'hf, 32'hffff_ffff, 32'h0);
    for (w = 1; w >= 0; w--)
    begin
      setenv(w ? BASE : 32'h0000_8000);
      wr(`ADDR_OPERATION_MODE, w << `BIT_WAIT_INPOS);
      rdc("mode", `ADDR_OPERATION_MODE, 32'h200, w << `BIT_WAIT_INPOS);
      ev(`EV_START_HS);
      rdc("cond run", EXT, 32'hf, `COND_RUN);
      ev(`EV_PULSE_DONE);
      chk("busy at done", busy, w);
      rdc("cond", EXT, 32'h1_000f, w ? `COND_WAIT_INPOS : `COND_IDLE);
      settled <= w[0];
      await("idle", 1, 20);
      rdc("inpos", EXT, 32'h1_0000, w << `BIT_STS_INPOS);
      settled <= 1'b0;
      tick(8);
    end
    $display("completion test over");
  endtask
  task automatic t_filter();
    int k;
    setenv(BASE | 32'h1 << `BIT_FILTER_EN);
    for (k = 40; k <= 100; k += 60)
    begin
      settled <= 1'b1;
      fault   <= 1'b1;
      tick(k);
      rdc("inpos", EXT, 32'h1_0000, 32'(k > 80) << `BIT_STS_INPOS);
      rdc("alarm", `ADDR_SUB_STATUS, 32'h800, 32'(k > 80) << `BIT_SUB_ALARM);
      settled <= 1'b0;
      fault   <= 1'b0;
      tick(120);
    end
    $display("filter test over");
  endtask
  task automatic t_clear();
    setenv(BASE | 32'h1 << `LSB_CLR_OFF_TIMER);
    wr(`ADDR_OPERATION_MODE, 32'h0);
    wr(`ADDR_COMMAND, `CMD_CLEAR_ON);
    for (n = 0; n < 2000 && clr; n++)
      tick();
    chk("width", 32'(n > 1494 && n < 1502), 1);
    ev(`EV_START_LS);
    chk("start in off time", busy, 0);
    tick(1500);
    ev(`EV_START_LS);
    chk("start after off time", busy, 1);
    ev(`EV_PULSE_DONE);
    setenv(32'h0040_7200);
    chk("clear idle", clr, 1);
    wr(`ADDR_COMMAND, `CMD_CLEAR_ON);
    tick(2000);
    chk("level clear", clr, 0);
    rdc("clear state", EXT, 32'h200, 32'h200);
    wr(`ADDR_COMMAND, `CMD_CLEAR_OFF);
    chk("clear off", clr, 1);
    rdc("clear state", EXT, 32'h200, 32'h0);
    $display("clear test over");
  endtask
  task automatic t_stops();
    int k;
    setenv(32'h0040_f600);
    for (k = 0; k < 4; k++)
    begin
      ev(`EV_START_HS);
      stp_mark = n_stp;
      case (k)
        0: fault <= 1'b1;
        1: wr(`ADDR_COMMAND, `CMD_EMERGENCY_STOP);
        2: ev(`EV_LIMIT_STOP);
        default: ev(`EV_EMG_STOP);
      endcase
      await("hard stop", 4, 20);
      tick();
      chk("clear at stop", clr, 1);
      chk("stop count", n_stp - stp_mark, 1);
      if (k == 0)
      begin
        rdc("cause", `ADDR_ERR_STOP_CAUSE, 32'h80, 32'h80);
        ev(`EV_START_HS);
        chk("start in alarm", busy, 0);
        fault <= 1'b0;
        tick(8);
      end
      else
        rdc("cause", `ADDR_ERR_STOP_CAUSE, 32'h80, 32'h0);
      wr(`ADDR_COMMAND, `CMD_CLEAR_OFF);
    end
    setenv(32'h0040_f700);
    for (k = `EV_START_HS; k >= `EV_START_LS; k--)
    begin
      ev(k);
      stp_mark = n_stp;
      fault <= 1'b1;
      await("alarm stop kind", k ? 3 : 4, 20);
      chk("stop count", n_stp - stp_mark, !k);
      chk("clear on decel", clr, !k);
      ev(`EV_DECEL_DONE);
      chk("busy after alarm", busy, 0);
      fault <= 1'b0;
      tick(8);
      wr(`ADDR_COMMAND, `CMD_CLEAR_OFF);
    end
    for (k = 0; k < 2; k++)
    begin
      setenv(BASE | 32'(k) << `BIT_CLR_ON_HOME_DONE);
      wr(`ADDR_AXIS_EVENT, 32'h9);
      ev(`EV_PULSE_DONE);
      chk("clear at home done", clr, k);
      rdc("event", `ADDR_AXIS_EVENT, 32'h7f, 32'h4);
      wr(`ADDR_COMMAND, `CMD_CLEAR_OFF);
    end
    $display("stop test over");
  endtask
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      stop_test();
    end
  end
  initial
  begin
    tick(6);
    srst_i <= 1'b0;
    tick();
    t_done();
    t_filter();
    t_clear();
    t_stops();
    stop_test();
  end
endmodule
bind servo_driver_interface servo_if_sva i_sva
(
  .mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .in_position_input_i(in_position_input_i),
  .alarm_input_i(alarm_input_i), .deviation_clear_output_o(deviation_clear_output_o),
  .busy_output_o(busy_output_o), .pulse_enable_o(pulse_enable_o),
  .decel_request_o(decel_request_o), .immediate_stop_o(immediate_stop_o)
);
`default_nettype wire
